// File: sim/tiwf_framer_tb.sv
// Self-checking bench for the trajectory intent word framer
`timescale 1ns/1ps

module tiwf_framer_tb;
    import tiwf_pkg::*;
    logic        ref_clk, reset_n, hold, slow;
    logic [3:0]  avs_address, avs_byteenable;
    logic        avs_read, avs_write, avs_waitrequest, tx_valid, tx_ready;
    logic [31:0] avs_writedata, avs_readdata, tx_word, rd;
    logic [15:0] crc;
    logic [31:0] exp_q[$];
    logic [22:0] ent_q[$];
    logic [7:0]  lbls[4] = '{TIWF_LBL_ACTIVE, TIWF_LBL_MODIF,
                             TIWF_LBL_SECOND, TIWF_LBL_DLINK};
    int          miscompares, compares, seed, seq, cnt;

    tiwf_framer i_tiwf_framer (.ref_clk(ref_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    tiwf_sink i_tiwf_sink (.ref_clk(ref_clk), .reset_n(reset_n),
        .hold(hold), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task check_word(input string n, input logic [31:0] e,
                    input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task check_reg(input string n, input logic [31:0] e,
                   input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    // Odd parity on top bit, fields placed as the line driver expects
    function automatic logic [31:0] mk(input logic [1:0] t, input logic b,
                                       input logic [19:0] f,
                                       input logic [7:0] l);
        logic [30:0] w;
        w = {t, b, f, l};
        return {~^w, w};
    endfunction

    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [31:0] w);
        logic fb;
        for (int i = 31; i >= 0; i--) begin
            fb = c[15] ^ w[i];
            c  = {c[14:0], 1'b0} ^ (fb ? TIWF_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    task bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    // Model a whole transfer, then push it, prefilling the queue if asked
    task xfer(input logic [1:0] p, input int frames, input int nd,
              input int pre);
        logic [3:0]  alt;
        logic [7:0]  wcnt;
        logic [22:0] e;
        logic [31:0] w;
        int          n;
        alt  = 4'($random(seed));
        wcnt = 8'($random(seed));
        bus_write(TIWF_ADDR_CFG, {20'h0, wcnt, alt});
        for (int f = 0; f < frames; f++) begin
            ent_q.push_back({TIWF_KIND_DESC, 8'h00, 13'($random(seed))});
            for (int i = 0; i < nd; i++) begin
                ent_q.push_back({TIWF_KIND_DATA, 21'($random(seed))});
            end
        end
        ent_q.push_back({(p == 2'h3) ? 2'h3 : TIWF_KIND_LAST, 21'h0});
        seq = 0;
        cnt = 0;
        crc = TIWF_CRC_INIT;
        exp_q.push_back(mk(TIWF_TYPE_BOUND, 1'b0, {alt, wcnt, 8'h00},
                           lbls[p]));
        foreach (ent_q[i]) begin
            e = ent_q[i];
            if (e[22:21] == TIWF_KIND_DESC || e[22:21] == TIWF_KIND_DATA) begin
                w = mk((e[22:21] == TIWF_KIND_DESC) ? TIWF_TYPE_DESC
                                                    : TIWF_TYPE_DATA,
                       e[20], e[19:0], lbls[p]);
                crc = crc_upd(crc, w);
                exp_q.push_back(w);
                cnt++;
                if (cnt == 253) begin
                    exp_q.push_back(mk(TIWF_TYPE_BOUND, 1'b1, {4'h0, crc},
                                       lbls[p]));
                    seq++;
                    cnt = 0;
                    crc = TIWF_CRC_INIT;
                    exp_q.push_back(mk(TIWF_TYPE_BOUND, 1'b0,
                                       {alt, wcnt, 8'(seq)}, lbls[p]));
                end
            end else begin
                exp_q.push_back(mk(TIWF_TYPE_BOUND, 1'b1, {4'h1, crc},
                                   lbls[p]));
            end
        end
        n = ent_q.size();
        for (int i = 0; i < n; i++) begin
            if (i == pre) begin
                if (pre > 0) begin
                    bus_read(TIWF_ADDR_STAT, rd);
                    check_reg("queue level", 32'(pre),
                              {27'h0, rd[20:16]});
                    hold <= 1'b0;
                end
                bus_write(TIWF_ADDR_CTRL, {29'h0, p, 1'b1});
            end
            bus_write(TIWF_ADDR_PUSH, {9'h0, ent_q[i]});
        end
        n = 0;
        while (exp_q.size() != 0 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        // Running out of time with words still owed counts as a mismatch
        check_reg("words left", 32'h0, 32'(exp_q.size()));
        exp_q.delete();
        ent_q.delete();
    endtask

    // Every word on the line is checked against the model
    always @(posedge ref_clk) begin
        slow <= 1'($random(seed));
        if (reset_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_word("extra tx_word", 32'h0, ~tx_word);
            end else begin
                check_word("tx_word", exp_q.pop_front(),
                           tx_word);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        summarize;
    end

    initial begin
        seed           = 63;
        reset_n        = 1'b0;
        hold           = 1'b1;
        slow           = 1'b0;
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        bus_write(4'h2, 32'hffffffff);
        bus_write(TIWF_ADDR_STAT, 32'hffffffff);
        foreach (lbls[i]) begin
            bus_read(4'(i * 4), rd);
            check_reg("reset value", 32'h0, rd);
        end
        bus_read(4'h2, rd);
        check_reg("unmapped read", 32'h0, rd);
        avs_byteenable <= 4'h1;
        bus_write(TIWF_ADDR_CFG, 32'h00000fff);
        avs_byteenable <= 4'hf;
        bus_read(TIWF_ADDR_CFG, rd);
        check_reg("cfg lane0", 32'h000000ff, rd);
        // Full queue before go, then 255 words to cross the unit limit
        xfer(2'h0, 1, 254, 16);
        for (int p = 1; p < 4; p++) begin
            xfer(2'(p), 2, 3, 0);
        end
        summarize;
    end
endmodule

// File: sim/tiwf_sink.sv
// Line driver partner that takes framer words, promptly or with stalls
`timescale 1ns/1ps

module tiwf_sink (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // Stall controls from the bench
    input  wire logic hold,
    input  wire logic slow,
    // Word stream
    input  wire logic tx_valid,
    output logic      tx_ready
);
    logic ph_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
        end
    end

    // Acknowledges words with tx_ready back, held low while hold is set
    // Slow mode only spaces words out, it never drops one
    assign tx_ready = !hold && (!slow || ph_q);
endmodule

// File: verilog/tiwf_framer.sv
// Trajectory intent word framer with register slave and word queue
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module tiwf_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    // Fill level
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } tiwf_fifo_state_type;

    tiwf_fifo_state_type s_q;
    tiwf_fifo_state_type s_d;
    logic                push;
    logic                pop;

    always_comb begin
        in_ready  = s_q.cnt != (AW+1)'(DEPTH);
        out_valid = s_q.cnt != '0;
        out_data  = s_q.mem[s_q.rp];
        level     = s_q.cnt;
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        s_d       = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

module tiwf_framer
    import tiwf_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Word stream to line driver
    output logic [31:0]      tx_word,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    tiwf_regs_type              r_q;
    tiwf_regs_type              r_d;
    logic                       q_in_valid;
    logic                       q_in_ready;
    logic                       q_out_valid;
    logic                       q_out_ready;
    logic [TIWF_Q_WIDTH-1:0]    q_out_data;
    logic [TIWF_Q_LVLW-1:0]     q_level;
    logic                       can_emit;
    logic                       emit_start;
    logic                       ldu_close;
    logic                       pop_desc;
    logic                       pop_data;
    logic                       pop_last;
    logic [7:0]                 label;

    function automatic logic [31:0] mk_word(input logic [1:0]  t,
                                            input logic [20:0] b,
                                            input logic [7:0]  l);
        logic [30:0] r;
        r = {t, b, l};
        return {~^r, r};
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [31:0] w);
        logic [15:0] x;
        x = c;
        for (int i = 31; i >= 0; i--) begin
            x = (x[15] ^ w[i]) ? ({x[14:0], 1'b0} ^ TIWF_CRC_POLY)
                               : {x[14:0], 1'b0};
        end
        return x;
    endfunction

    function automatic logic [7:0] plan_label(input logic [1:0] p);
        logic [7:0] l;
        l = TIWF_LBL_ACTIVE;
        unique case (p)
            2'h0: l = TIWF_LBL_ACTIVE;
            2'h1: l = TIWF_LBL_MODIF;
            2'h2: l = TIWF_LBL_SECOND;
            2'h3: l = TIWF_LBL_DLINK;
        endcase
        return l;
    endfunction

    function automatic logic [7:0] be_merge(input logic [7:0] o,
                                            input logic [7:0] n,
                                            input logic       e);
        return e ? n : o;
    endfunction

    tiwf_fifo #(
        .WIDTH (TIWF_Q_WIDTH),
        .DEPTH (TIWF_Q_DEPTH)
    ) u_queue (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (q_in_valid),
        .in_ready  (q_in_ready),
        .in_data   (avs_writedata[TIWF_Q_WIDTH-1:0]),
        .out_valid (q_out_valid),
        .out_ready (q_out_ready),
        .out_data  (q_out_data),
        .level     (q_level)
    );

    always_comb begin
        logic [31:0] w;
        logic [7:0]  lo;
        logic [7:0]  hi;
        w           = '0;
        lo          = '0;
        hi          = '0;
        r_d         = r_q;
        label       = plan_label(r_q.plan);
        q_in_valid  = 1'b0;
        q_out_ready = 1'b0;
        emit_start  = 1'b0;
        ldu_close   = 1'b0;
        pop_desc    = 1'b0;
        pop_data    = 1'b0;
        pop_last    = 1'b0;
        can_emit    = !r_q.tx_valid || tx_ready;
        if (r_q.tx_valid && tx_ready) begin
            r_d.tx_valid = 1'b0;
        end
        // Never waits on any receiver, only on the start request, the local line driver and entries in the word queue
        unique case (r_q.st)
            ST_IDLE: begin
                if (r_q.go) begin
                    r_d.go  = 1'b0;
                    r_d.seq = '0;
                    r_d.st  = ST_START;
                end
            end
            ST_START: begin
                if (can_emit) begin
                    emit_start   = 1'b1;
                    r_d.tx_word  = mk_word(TIWF_TYPE_BOUND,
                        {1'b0, r_q.alt, r_q.wcount, r_q.seq},
                        label);
                    r_d.tx_valid = 1'b1;
                    r_d.cnt      = '0;
                    r_d.crc      = TIWF_CRC_INIT;
                    r_d.st       = ST_BODY;
                end
            end
            ST_BODY: begin
                if (can_emit && r_q.cnt == TIWF_LDU_LIMIT) begin
                    // Unit full: close it before taking the next entry
                    ldu_close    = 1'b1;
                    r_d.tx_word  = mk_word(TIWF_TYPE_BOUND,
                        {1'b1, 3'h0, 1'b0, r_q.crc}, label);
                    r_d.tx_valid = 1'b1;
                    r_d.seq      = r_q.seq + 8'h01;
                    r_d.st       = ST_START;
                end else if (can_emit && q_out_valid) begin
                    q_out_ready = 1'b1;
                    if (q_out_data[TIWF_PUSH_KIND+1]) begin
                        pop_last     = 1'b1;
                        r_d.tx_word  = mk_word(TIWF_TYPE_BOUND,
                            {1'b1, 3'h0, 1'b1, r_q.crc}, label);
                        r_d.tx_valid = 1'b1;
                        r_d.st       = ST_IDLE;
                    end else begin
                        if (q_out_data[TIWF_PUSH_KIND]) begin
                            pop_desc = 1'b1;
                            w = mk_word(TIWF_TYPE_DESC,
                                {8'h00, q_out_data[12:0]},
                                label);
                        end else begin
                            pop_data = 1'b1;
                            // Validity bit and ETA body pass unchanged
                            w = mk_word(TIWF_TYPE_DATA,
                                q_out_data[20:0], label);
                        end
                        r_d.tx_word  = w;
                        r_d.tx_valid = 1'b1;
                        r_d.cnt      = r_q.cnt + 8'h01;
                        r_d.crc      = crc_step(r_q.crc, w);
                    end
                end
            end
        endcase
        // Bus: first cycle decodes, second completes
        if ((avs_read || avs_write) && r_q.waitreq) begin
            // Full queue stalls the push until room opens
            if (!(avs_write && avs_address == TIWF_ADDR_PUSH
                  && !q_in_ready)) begin
                r_d.waitreq = 1'b0;
                unique case (avs_address)
                    TIWF_ADDR_CTRL: r_d.rdata = {29'h0, r_q.plan, 1'b0};
                    TIWF_ADDR_CFG:  r_d.rdata = {20'h0, r_q.wcount, r_q.alt};
                    TIWF_ADDR_STAT: r_d.rdata = {7'h0, r_q.st != ST_IDLE,
                        3'h0, q_level, r_q.cnt, r_q.seq};
                    default:        r_d.rdata = '0;
                endcase
            end
        end else if (avs_read || avs_write) begin
            r_d.waitreq = 1'b1;
            if (avs_write) begin
                unique case (avs_address)
                    TIWF_ADDR_CTRL: begin
                        lo = be_merge({5'h0, r_q.plan, 1'b0},
                                      avs_writedata[7:0], avs_byteenable[0]);
                        r_d.plan = lo[TIWF_CTRL_PLAN+:2];
                        // Start request set wins over the idle consume
                        if (lo[TIWF_CTRL_GO]) begin
                            r_d.go = 1'b1;
                        end
                    end
                    TIWF_ADDR_CFG: begin
                        lo = be_merge({r_q.wcount[3:0], r_q.alt},
                                      avs_writedata[7:0], avs_byteenable[0]);
                        r_d.alt    = lo[TIWF_CFG_ALT+:4];
                        hi = be_merge({4'h0, r_q.wcount[7:4]},
                                      avs_writedata[15:8], avs_byteenable[1]);
                        r_d.wcount = {hi[3:0], lo[7:4]};
                    end
                    TIWF_ADDR_PUSH: q_in_valid = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            r_q <= TIWF_REGS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign avs_readdata    = r_q.rdata;
    assign avs_waitrequest = r_q.waitreq;
    assign tx_word         = r_q.tx_word;
    assign tx_valid        = r_q.tx_valid;

    a_start_word_form: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        emit_start |=> tx_valid && tx_word[30:29] == 2'h3
            && !tx_word[28] && tx_word[15:8] == $past(r_q.seq)
            && tx_word[23:16] == $past(r_q.wcount))
        else $error("start word malformed");

    a_start_alt_bits: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        emit_start |=> tx_word[27:24] == $past(r_q.alt))
        else $error("alternate content bits wrong");

    a_desc_word_form: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pop_desc |=> tx_word[30:29] == 2'h1 && tx_word[28:21] == 8'h00
            && tx_word[20:15] == $past(q_out_data[12:7])
            && tx_word[11:8] == $past(q_out_data[3:0]))
        else $error("descriptor word malformed");

    a_desc_geometry: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pop_desc |=> tx_word[14:12] == $past(q_out_data[6:4]))
        else $error("geometry field misplaced");

    a_frame_continues: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (pop_desc || pop_data) |=> r_q.st == ST_BODY
            && r_q.cnt == $past(r_q.cnt) + 8'h01)
        else $error("frame did not continue");

    a_ldu_limit_close: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (r_q.st == ST_BODY && r_q.cnt == TIWF_LDU_LIMIT && can_emit)
        |-> ldu_close
        ##1 (tx_word[30:29] == 2'h3 && !tx_word[24] && r_q.st == ST_START)
        // A stalled driver delays the new start word by up to two cycles
        ##[1:3] (tx_valid && tx_word[30:29] == 2'h3 && !tx_word[28]))
        else $error("unit not closed at limit");

    a_end_word_form: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pop_last |=> tx_word[30:29] == 2'h3 && tx_word[27:25] == 3'h0
            && tx_word[24] && tx_word[23:8] == $past(r_q.crc)
            && r_q.st == ST_IDLE)
        else $error("end word malformed");

    a_data_validity: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pop_data |=> tx_word[28] == $past(q_out_data[20])
            && tx_word[27:8] == $past(q_out_data[19:0]))
        else $error("data validity bit altered");

    a_data_type_lbl: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pop_data |=> tx_word[30:29] == 2'h0 && tx_word[7:0] == $past(label)
            && ^tx_word)
        else $error("data word type or label wrong");
endmodule

// File: verilog/tiwf_pkg.sv
// Constants and types for the trajectory intent word framer
package tiwf_pkg;
    // Register byte addresses
    localparam logic [3:0]  TIWF_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  TIWF_ADDR_CFG    = 4'h4;
    localparam logic [3:0]  TIWF_ADDR_PUSH   = 4'h8;
    localparam logic [3:0]  TIWF_ADDR_STAT   = 4'hc;
    // Field positions
    localparam int          TIWF_CTRL_GO     = 0;
    localparam int          TIWF_CTRL_PLAN   = 1;
    localparam int          TIWF_CFG_ALT     = 0;
    localparam int          TIWF_CFG_WCNT    = 4;
    localparam int          TIWF_PUSH_KIND   = 21;
    // Queue entry kinds
    localparam logic [1:0]  TIWF_KIND_DATA   = 2'h0;
    localparam logic [1:0]  TIWF_KIND_DESC   = 2'h1;
    localparam logic [1:0]  TIWF_KIND_LAST   = 2'h2;
    // Word type bits 30,29
    localparam logic [1:0]  TIWF_TYPE_DATA   = 2'h0;
    localparam logic [1:0]  TIWF_TYPE_DESC   = 2'h1;
    localparam logic [1:0]  TIWF_TYPE_BOUND  = 2'h3;
    // Flight plan labels, octal 232, 242, 252, 262
    localparam logic [7:0]  TIWF_LBL_ACTIVE  = 8'h9a;
    localparam logic [7:0]  TIWF_LBL_MODIF   = 8'ha2;
    localparam logic [7:0]  TIWF_LBL_SECOND  = 8'haa;
    localparam logic [7:0]  TIWF_LBL_DLINK   = 8'hb2;
    // Descriptor and data words per link data unit
    localparam logic [7:0]  TIWF_LDU_LIMIT   = 8'hfd;
    // Block check
    localparam logic [15:0] TIWF_CRC_POLY    = 16'h1021;
    localparam logic [15:0] TIWF_CRC_INIT    = 16'hffff;
    // Queue shape
    localparam int          TIWF_Q_WIDTH     = 23;
    localparam int          TIWF_Q_DEPTH     = 16;
    localparam int          TIWF_Q_LVLW      = 5;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BODY} tiwf_state_type;

    typedef struct packed {
        tiwf_state_type st;
        logic [7:0]     seq;
        logic [7:0]     cnt;
        logic [15:0]    crc;
        logic [1:0]     plan;
        logic [3:0]     alt;
        logic [7:0]     wcount;
        logic           go;
        logic [31:0]    tx_word;
        logic           tx_valid;
        logic           waitreq;
        logic [31:0]    rdata;
    } tiwf_regs_type;

    localparam tiwf_regs_type TIWF_REGS_RESET =
        '{st: ST_IDLE, waitreq: 1'b1, default: '0};
endpackage
